// file: rtl/trim_ov_regs.sv
`timescale 1ns/1ps
// Functional notes
// RL1: Gain trim change rescales effective overcurrent fault and warn thresholds.
// RL2: Out-of-range gain, offset, limit or action write flags invalid data, alerts.
// RL3: Power cycle or store/restore rounds gain to nearest 1/64, capped 1.984.
// RL4: Each phase keeps its own offset; stack offset is their sum.
// RL5: Per-phase offset accepted only from -8 A to +7.9375 A.
// RL6: High-resolution offsets accepted live; restore reloads nearest stored value.
// RL7: Single phase selector writes and reads only that phase's offset.
// RL8: All-phase offset write divides value by phase count into each phase.
// RL9: All-phase offset read returns phase zero offset times phase count.
// RL10: Overvoltage threshold held as fraction of target, even in absolute mode.
// RL11: Overvoltage detection armed from reset release, regardless of conversion.
// RL12: Converting, limit rounds up to 105..140 percent in 2.5 percent steps.
// RL13: Not converting, threshold restricted to 110..140 percent in 10 percent steps.
// RL14: Overvoltage fault handled per configured action byte.
// RL15: Overvoltage sets status byte, word and output status bits, alerts host.
// RL16: Action uses byte transactions; gain, offset and limit use word ones.
// RL17: Action field 00 ignores, 01/10 shut down and retry, 11 invalid.
// RL18: Retry field 0 latches, 1..6 retries that many, 7 retries forever.
// RL19: Hiccup wait is one rise time for 0, else field times rise time.
// RL20: Reads return last written words; hardware uses rounded values.
module trim_ov_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Command port
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic cmd_byte,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data,
  output logic rd_valid,
  // Stack and phase selection
  input wire logic [7:0] phase_sel,
  input wire logic [2:0] num_phases,
  // Store and restore, status clear
  input wire logic nvm_store,
  input wire logic nvm_restore,
  input wire logic clear_faults,
  // Output voltage sensing
  input wire logic conv_en,
  input wire logic vout_abs_mode,
  input wire logic [15:0] vout_target,
  input wire logic [15:0] vout_sense,
  input wire logic [15:0] ton_rise_cycles,
  // Overcurrent limits in; scaled limits, gain, stack offset and threshold out
  input wire logic [15:0] oc_fault_in,
  input wire logic [15:0] oc_warn_in,
  output logic [15:0] eff_oc_fault,
  output logic [15:0] eff_oc_warn,
  output logic [15:0] eff_gain_q10,
  output logic [15:0] stack_offset_q8,
  output logic [9:0] ov_pct_q,
  // Fault reaction and status
  output logic shutdown,
  output logic latched_off,
  output logic status_byte_ov,
  output logic status_word_vout,
  output logic status_vout_ov,
  output logic status_cml_data,
  output logic alert_n
);
  typedef struct packed {
    logic [15:0] gain_raw;
    logic signed [15:0] gain_q10;
    logic [trim_ov_pkg::PHASES-1:0][15:0] off_raw;
    logic [trim_ov_pkg::PHASES-1:0][15:0] off_q8;
    logic signed [15:0] off_sum;
    logic [15:0] ovl_raw;
    logic [3:0] ov_step;
    logic [7:0] action;
    logic [6:0] nv_gain;
    logic [trim_ov_pkg::PHASES-1:0][7:0] nv_off;
    logic [15:0] rd_data;
    logic rd_valid;
    logic [15:0] eff_fault;
    logic [15:0] eff_warn;
    logic st_byte_ov;
    logic st_word_vout;
    logic st_vout_ov;
    logic st_cml;
    trim_ov_pkg::ov_state_t ov_state;
    logic [18:0] hic_cnt;
    logic [15:0] ok_cnt;
    logic [2:0] tries;
    logic shut;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // Linear11 word to rounded signed fixed point with fb fraction bits
  function automatic int lin_fix(input logic [15:0] w, input int fb);
    int m;
    int sh;
    m = int'($signed(w[trim_ov_pkg::MAN_MSB:0]));
    sh = int'($signed(w[15:trim_ov_pkg::EXP_LSB])) + fb;
    if (sh > 16) begin
      lin_fix = (m == 0) ? 0 : ((m < 0) ? -(1 <<< 30) : (1 <<< 30));
    end else if (sh >= 0) begin
      lin_fix = m <<< sh;
    end else if (sh < -20) begin
      lin_fix = 0;
    end else begin
      lin_fix = (m + (1 <<< (-sh - 1))) >>> (-sh);
    end
  endfunction : lin_fix

  // Round right shift with saturation
  function automatic int round_sat(input int v, input int sh, input int lo, input int hi);
    int r;
    r = (v + (1 <<< (sh - 1))) >>> sh;
    round_sat = (r < lo) ? lo : ((r > hi) ? hi : r);
  endfunction : round_sat

  // Smallest running step at or above the requested limit
  function automatic logic [3:0] ov_step_of(input logic [15:0] lim, input int ref_v);
    logic found;
    ov_step_of = trim_ov_pkg::STEP_BAD;
    found = 1'b0;
    for (int k = 0; k < trim_ov_pkg::RUN_STEPS; k++) begin
      if (!found && (int'(lim) * trim_ov_pkg::PCT_SCALE <=
          (trim_ov_pkg::RUN_BASE + k * trim_ov_pkg::RUN_STEP) * ref_v)) begin
        ov_step_of = 4'(k);
        found = 1'b1;
      end
    end
  endfunction : ov_step_of

  // Quarter-percent threshold for a step, coarsened while not converting
  function automatic logic [9:0] pct_of(input logic [3:0] step, input logic run);
    int p;
    int q;
    p = trim_ov_pkg::RUN_BASE + int'(step) * trim_ov_pkg::RUN_STEP;
    q = trim_ov_pkg::OFF_BASE;
    for (int k = 0; k < trim_ov_pkg::RUN_STEPS; k++) begin
      if (q < p) begin
        q = q + trim_ov_pkg::OFF_STEP;
      end
    end
    pct_of = run ? 10'(p) : 10'(q);
  endfunction : pct_of

  logic [9:0] pct;
  logic ov_hit;
  logic [2:0] nph;
  logic [1:0] act;
  logic [2:0] retry;
  logic [2:0] hic;
  logic [18:0] hic_wait;
  int g;
  int o;
  int q;
  int pi;
  logic [3:0] stp;
  logic bad;

  // Threshold fraction of the present target
  // RL10 relative threshold
  // RL12 RL13 step selection
  assign pct = pct_of(st_r.ov_step, conv_en);
  // RL11 always armed
  assign ov_hit = 32'(vout_sense) * 32'(trim_ov_pkg::PCT_SCALE) >
                  32'(pct) * 32'(vout_target);
  assign nph = (num_phases == 3'h0) ? 3'h1 : num_phases;
  assign act = st_r.action[trim_ov_pkg::ACT_MSB:trim_ov_pkg::ACT_LSB];
  assign retry = st_r.action[trim_ov_pkg::RETRY_MSB:trim_ov_pkg::RETRY_LSB];
  assign hic = st_r.action[trim_ov_pkg::HICCUP_MSB:0];
  // RL19 hiccup length
  assign hic_wait = 19'((hic == 3'h0) ? 3'h1 : hic) * 19'(ton_rise_cycles);

  always_comb begin
    st_nxt = st_r;
    g = lin_fix(wr_data, trim_ov_pkg::GAIN_FB);
    o = lin_fix(wr_data, trim_ov_pkg::OFF_FB);
    q = o / int'(nph);
    pi = int'(phase_sel[1:0]);
    stp = ov_step_of(wr_data, vout_abs_mode ? int'(vout_target) : trim_ov_pkg::REL_ONE);
    bad = 1'b0;
    st_nxt.rd_valid = 1'b0;
    if (cmd_wr) begin
      case (cmd_code)
        trim_ov_pkg::CMD_GAIN: begin
          // RL16 RL2 gain range
          bad = cmd_byte || g < 0 || g > trim_ov_pkg::GAIN_MAX_Q10;
          if (!bad) begin
            st_nxt.gain_raw = wr_data;
            st_nxt.gain_q10 = 16'(g);
          end
        end
        trim_ov_pkg::CMD_OFFSET: begin
          if (phase_sel == trim_ov_pkg::PHASE_ALL) begin
            // RL8 equal split
            bad = cmd_byte || q < trim_ov_pkg::OFF_MIN_Q8 || q > trim_ov_pkg::OFF_MAX_Q8;
            for (int i = 0; i < trim_ov_pkg::PHASES; i++) begin
              if (!bad && i < int'(nph)) begin
                st_nxt.off_q8[i] = 16'(q);
                st_nxt.off_raw[i] = {trim_ov_pkg::OFFSET_EXP,
                                     11'(q >>> trim_ov_pkg::OFF_READ_SHIFT)};
              end
            end
          end else begin
            // RL5 RL6 RL7 single phase in range
            bad = cmd_byte || phase_sel >= 8'(nph) ||
                  o < trim_ov_pkg::OFF_MIN_Q8 || o > trim_ov_pkg::OFF_MAX_Q8;
            if (!bad) begin
              st_nxt.off_q8[pi] = 16'(o);
              st_nxt.off_raw[pi] = wr_data;
            end
          end
        end
        trim_ov_pkg::CMD_OV_LIMIT: begin
          // RL2 RL12 round up, reject above range
          bad = cmd_byte || stp == trim_ov_pkg::STEP_BAD ||
                (vout_abs_mode && vout_target == 16'h0000);
          if (!bad) begin
            st_nxt.ovl_raw = wr_data;
            st_nxt.ov_step = stp;
          end
        end
        trim_ov_pkg::CMD_OV_ACTION: begin
          // RL16 RL17 byte only, code 11 invalid
          bad = !cmd_byte || wr_data[trim_ov_pkg::ACT_MSB:trim_ov_pkg::ACT_LSB] ==
                trim_ov_pkg::ACT_BAD;
          if (!bad) begin
            st_nxt.action = wr_data[7:0];
          end
        end
        default: bad = 1'b1;
      endcase
    end
    if (cmd_rd) begin
      st_nxt.rd_valid = 1'b1;
      // RL20 last written words
      case (cmd_code)
        trim_ov_pkg::CMD_GAIN: st_nxt.rd_data = st_r.gain_raw;
        trim_ov_pkg::CMD_OFFSET: begin
          // RL9 phase zero times count
          if (phase_sel == trim_ov_pkg::PHASE_ALL) begin
            st_nxt.rd_data = {trim_ov_pkg::OFFSET_EXP, 11'((int'($signed(st_r.off_q8[0])) *
                              int'(nph)) >>> trim_ov_pkg::OFF_READ_SHIFT)};
          end else begin
            st_nxt.rd_data = st_r.off_raw[pi];
          end
        end
        trim_ov_pkg::CMD_OV_LIMIT: st_nxt.rd_data = st_r.ovl_raw;
        trim_ov_pkg::CMD_OV_ACTION: st_nxt.rd_data = {8'h00, st_r.action};
        default: st_nxt.rd_data = 16'h0000;
      endcase
    end
    // RL3 RL6 quantised store and restore
    if (nvm_store) begin
      st_nxt.nv_gain = 7'(round_sat(int'(st_r.gain_q10), trim_ov_pkg::GAIN_NVM_SHIFT, 0,
                                    trim_ov_pkg::GAIN_NVM_MAX));
      for (int i = 0; i < trim_ov_pkg::PHASES; i++) begin
        st_nxt.nv_off[i] = 8'(round_sat(int'($signed(st_r.off_q8[i])),
                                        trim_ov_pkg::OFF_NVM_SHIFT,
                                        trim_ov_pkg::OFF_NVM_MIN, trim_ov_pkg::OFF_NVM_MAX));
      end
    end
    if (nvm_restore) begin
      st_nxt.gain_q10 = 16'(st_nxt.nv_gain) <<< trim_ov_pkg::GAIN_NVM_SHIFT;
      st_nxt.gain_raw = {trim_ov_pkg::GAIN_NVM_EXP, 4'h0, st_nxt.nv_gain};
      for (int i = 0; i < trim_ov_pkg::PHASES; i++) begin
        st_nxt.off_q8[i] = 16'($signed(st_nxt.nv_off[i])) <<< trim_ov_pkg::OFF_NVM_SHIFT;
        st_nxt.off_raw[i] = {trim_ov_pkg::OFFSET_EXP, 11'($signed(st_nxt.nv_off[i]))};
      end
    end
    // RL4 stack offset sum
    st_nxt.off_sum = 16'h0000;
    for (int i = 0; i < trim_ov_pkg::PHASES; i++) begin
      if (i < int'(nph)) begin
        st_nxt.off_sum = st_nxt.off_sum + $signed(st_r.off_q8[i]);
      end
    end
    // RL1 gain scaled overcurrent limits
    st_nxt.eff_fault = 16'((32'(oc_fault_in) * 32'(st_r.gain_q10)) >> trim_ov_pkg::GAIN_FB);
    st_nxt.eff_warn = 16'((32'(oc_warn_in) * 32'(st_r.gain_q10)) >> trim_ov_pkg::GAIN_FB);
    // RL14 RL17 RL18 fault reaction
    case (st_r.ov_state)
      trim_ov_pkg::OV_RUN: begin
        if (ov_hit && act != trim_ov_pkg::ACT_IGNORE) begin
          st_nxt.shut = 1'b1;
          st_nxt.hic_cnt = 19'h0_0000;
          if (retry == trim_ov_pkg::RETRY_NONE ||
              (retry != trim_ov_pkg::RETRY_FOREVER && st_r.tries >= retry)) begin
            st_nxt.ov_state = trim_ov_pkg::OV_LATCHED;
          end else begin
            st_nxt.ov_state = trim_ov_pkg::OV_HICCUP;
            st_nxt.tries = (st_r.tries == trim_ov_pkg::RETRY_FOREVER) ? st_r.tries :
                           st_r.tries + 3'h1;
          end
        end else if (st_r.ok_cnt >= ton_rise_cycles) begin
          st_nxt.tries = 3'h0;
        end else begin
          st_nxt.ok_cnt = st_r.ok_cnt + 16'h0001;
        end
      end
      trim_ov_pkg::OV_HICCUP: begin
        // RL19 wait then restart
        st_nxt.hic_cnt = st_r.hic_cnt + 19'h0_0001;
        if (st_nxt.hic_cnt >= hic_wait) begin
          st_nxt.ov_state = trim_ov_pkg::OV_RUN;
          st_nxt.shut = 1'b0;
          st_nxt.ok_cnt = 16'h0000;
        end
      end
      trim_ov_pkg::OV_LATCHED: begin
        if (!conv_en) begin
          st_nxt.ov_state = trim_ov_pkg::OV_RUN;
          st_nxt.shut = 1'b0;
          st_nxt.tries = 3'h0;
          st_nxt.ok_cnt = 16'h0000;
        end
      end
      default: st_nxt.ov_state = trim_ov_pkg::OV_RUN;
    endcase
    // RL15 RL2 sticky status, set wins over clear
    if (clear_faults) begin
      st_nxt.st_byte_ov = 1'b0;
      st_nxt.st_word_vout = 1'b0;
      st_nxt.st_vout_ov = 1'b0;
      st_nxt.st_cml = 1'b0;
    end
    if (ov_hit) begin
      st_nxt.st_byte_ov = 1'b1;
      st_nxt.st_word_vout = 1'b1;
      st_nxt.st_vout_ov = 1'b1;
    end
    if (bad) begin
      st_nxt.st_cml = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r <= '0;
      st_r.gain_raw <= trim_ov_pkg::GAIN_RST;
      st_r.gain_q10 <= 16'(1 <<< trim_ov_pkg::GAIN_FB);
      st_r.nv_gain <= 7'(1 <<< (trim_ov_pkg::GAIN_FB - trim_ov_pkg::GAIN_NVM_SHIFT));
      st_r.off_raw <= {trim_ov_pkg::PHASES{trim_ov_pkg::OFFSET_RST}};
      st_r.ovl_raw <= trim_ov_pkg::OV_LIMIT_RST;
      st_r.ov_step <= trim_ov_pkg::OV_STEP_RST;
      st_r.action <= trim_ov_pkg::OV_ACTION_RST;
      st_r.ov_state <= trim_ov_pkg::OV_RUN;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data = st_r.rd_data;
  assign rd_valid = st_r.rd_valid;
  assign eff_oc_fault = st_r.eff_fault;
  assign eff_oc_warn = st_r.eff_warn;
  assign eff_gain_q10 = st_r.gain_q10;
  assign stack_offset_q8 = st_r.off_sum;
  assign ov_pct_q = pct;
  assign shutdown = st_r.shut;
  assign latched_off = st_r.ov_state == trim_ov_pkg::OV_LATCHED;
  assign status_byte_ov = st_r.st_byte_ov;
  assign status_word_vout = st_r.st_word_vout;
  assign status_vout_ov = st_r.st_vout_ov;
  assign status_cml_data = st_r.st_cml;
  assign alert_n = !(st_r.st_byte_ov || st_r.st_word_vout || st_r.st_vout_ov || st_r.st_cml);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence gain_write_s;
    cmd_wr && cmd_code == trim_ov_pkg::CMD_GAIN && !bad && !nvm_restore;
  endsequence
  sequence latch_fault_s;
    st_r.ov_state == trim_ov_pkg::OV_RUN && ov_hit && act != trim_ov_pkg::ACT_IGNORE &&
    retry == trim_ov_pkg::RETRY_NONE;
  endsequence

  // RL1 rescaled fault threshold
  gain_rescale_a: assert property (gain_write_s ##1 $stable(oc_fault_in) |=> // RL1
    eff_oc_fault == 16'((32'($past(oc_fault_in)) * 32'($past(wr_data, 2) == st_r.gain_raw ?
    st_r.gain_q10 : $past(st_r.gain_q10))) >> trim_ov_pkg::GAIN_FB)) else $error("gain scale");
  // RL2 invalid flag
  invalid_flag_a: assert property (cmd_wr && bad |=> status_cml_data && !alert_n) // RL2
    else $error("invalid data not flagged");
  // RL3 restored gain quantised
  gain_round_a: assert property (nvm_restore |=> eff_gain_q10[3:0] == 4'h0 && // RL3
    int'(eff_gain_q10) <= trim_ov_pkg::GAIN_MAX_Q10) else $error("gain not rounded");
  // RL5 offset range
  offset_range_a: assert property (int'($signed(st_r.off_q8[1])) >= // RL5
    trim_ov_pkg::OFF_MIN_Q8 && int'($signed(st_r.off_q8[1])) <= trim_ov_pkg::OFF_MAX_Q8)
    else $error("offset out of range");
  // RL7 other phases untouched
  phase_write_a: assert property (cmd_wr && cmd_code == trim_ov_pkg::CMD_OFFSET && // RL7
    phase_sel == 8'h00 && !nvm_restore |=> $stable(st_r.off_q8[3:1]))
    else $error("single phase write leaked");
  // RL8 equal split
  all_split_a: assert property (cmd_wr && cmd_code == trim_ov_pkg::CMD_OFFSET && // RL8
    phase_sel == trim_ov_pkg::PHASE_ALL && !bad && num_phases == 3'h4 && !nvm_restore |=>
    st_r.off_q8[0] == st_r.off_q8[3]) else $error("split not equal");
  // RL13 coarse steps when idle
  idle_step_a: assert property (!conv_en |-> (int'(ov_pct_q) - // RL13
    trim_ov_pkg::OFF_BASE) % trim_ov_pkg::OFF_STEP == 0) else $error("idle step wrong");
  // RL15 overvoltage status
  ov_flags_a: assert property (ov_hit |=> status_vout_ov && status_byte_ov && // RL15
    status_word_vout && !alert_n) else $error("ov flags missing");
  // RL18 latch off with zero retries
  // Latch holds only while conversion stays commanded on
  latch_off_a: assert property (latch_fault_s ##1 conv_en |-> // RL18
    latched_off && shutdown ##1 latched_off && shutdown) else $error("no latch off");
  // RL17 ignore keeps running
  ignore_a: assert property (act == trim_ov_pkg::ACT_IGNORE && // RL17
    st_r.ov_state == trim_ov_pkg::OV_RUN && !shutdown |=> !shutdown)
    else $error("ignore shut down");
endmodule : trim_ov_regs

// file: rtl/trim_ov_pkg.sv
package trim_ov_pkg;
  // Command codes
  localparam logic [7:0] CMD_GAIN = 8'h38;
  localparam logic [7:0] CMD_OFFSET = 8'h39;
  localparam logic [7:0] CMD_OV_LIMIT = 8'h40;
  localparam logic [7:0] CMD_OV_ACTION = 8'h41;
  localparam logic [7:0] PHASE_ALL = 8'hff;
  localparam int PHASES = 4;
  // Reset words
  localparam logic [15:0] GAIN_RST = 16'hc880;
  localparam logic [15:0] OFFSET_RST = 16'he000;
  localparam logic [15:0] OV_LIMIT_RST = 16'h0250;
  localparam logic [7:0] OV_ACTION_RST = 8'h80;
  localparam logic [3:0] OV_STEP_RST = 4'h4;
  // Linear word layout
  localparam int EXP_LSB = 11;
  localparam int MAN_MSB = 10;
  localparam logic [4:0] OFFSET_EXP = 5'h1c;
  localparam logic [4:0] GAIN_NVM_EXP = 5'h1a;
  // Fixed point scales and limits
  localparam int GAIN_FB = 10;
  localparam int OFF_FB = 8;
  localparam int GAIN_MAX_Q10 = 32'h0000_07f0;
  localparam int GAIN_NVM_SHIFT = 4;
  localparam int GAIN_NVM_MAX = 32'h0000_007f;
  localparam int OFF_MIN_Q8 = -32'h0000_0800;
  localparam int OFF_MAX_Q8 = 32'h0000_07f0;
  localparam int OFF_NVM_SHIFT = 4;
  localparam int OFF_NVM_MIN = -32'h0000_0080;
  localparam int OFF_NVM_MAX = 32'h0000_007f;
  localparam int OFF_READ_SHIFT = 4;
  // Threshold steps in quarter percent
  localparam int PCT_SCALE = 32'h0000_0190;
  localparam int REL_ONE = 32'h0000_0200;
  localparam int RUN_BASE = 32'h0000_01a4;
  localparam int RUN_STEP = 32'h0000_000a;
  localparam int RUN_STEPS = 32'h0000_000f;
  localparam int OFF_BASE = 32'h0000_01b8;
  localparam int OFF_STEP = 32'h0000_0028;
  localparam logic [3:0] STEP_BAD = 4'hf;
  // Action byte fields
  localparam int ACT_MSB = 7;
  localparam int ACT_LSB = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int HICCUP_MSB = 2;
  localparam logic [1:0] ACT_IGNORE = 2'h0;
  localparam logic [1:0] ACT_BAD = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  typedef enum logic [1:0] {OV_RUN, OV_HICCUP, OV_LATCHED} ov_state_t;
endpackage : trim_ov_pkg

// file: testbench/host_model.sv
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic clk,
  // Command port
  output logic cmd_wr,
  output logic cmd_rd,
  output logic cmd_byte,
  output logic [7:0] cmd_code,
  output logic [15:0] wr_data,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid
);
  initial begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_byte = 1'b0;
    cmd_code = 8'h00;
    wr_data = 16'h0000;
  end

  // byte or word transfer per call
  task automatic put(input logic [7:0] code, input logic [15:0] data, input logic is_byte);
    @(posedge clk);
    cmd_wr <= 1'b1;
    cmd_byte <= is_byte;
    cmd_code <= code;
    wr_data <= data;
    @(posedge clk);
    cmd_wr <= 1'b0;
    wr_data <= ~data;
    #1;
  endtask : put

  // byte or word read per call
  task automatic get(input logic [7:0] code, input logic is_byte, output logic [15:0] data,
                     output logic ok);
    @(posedge clk);
    cmd_rd <= 1'b1;
    cmd_byte <= is_byte;
    cmd_code <= code;
    @(posedge clk);
    cmd_rd <= 1'b0;
    #1;
    ok = rd_valid;
    data = rd_data;
  endtask : get
endmodule : host_model

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] phase_sel = 8'h00;
  logic [2:0] num_phases = 3'h4;
  logic nvm_store = 1'b0;
  logic nvm_restore = 1'b0;
  logic clear_faults = 1'b0;
  logic conv_en = 1'b0;
  logic vout_abs_mode = 1'b0;
  logic [15:0] vout_target = 16'h1000;
  logic [15:0] vout_sense = 16'h0800;
  logic [15:0] oc_fault_in = 16'h0100;
  logic [15:0] oc_warn_in = 16'h0200;
  logic cmd_wr, cmd_rd, cmd_byte, rd_valid, shutdown, latched_off, alert_n;
  logic status_byte_ov, status_word_vout, status_vout_ov, status_cml_data;
  logic [7:0] cmd_code;
  logic [15:0] wr_data, rd_data, eff_oc_fault, eff_oc_warn, eff_gain_q10, stack_offset_q8;
  logic [9:0] ov_pct_q;
  int bad_count = 0;
  int checks = 0;

  always #20 clk = ~clk;

  host_model host (.clk(clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_byte(cmd_byte),
    .cmd_code(cmd_code), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid));

  trim_ov_regs dut (.clk(clk), .rstn(rstn), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_byte(cmd_byte), .cmd_code(cmd_code), .wr_data(wr_data), .rd_data(rd_data),
    .rd_valid(rd_valid), .phase_sel(phase_sel), .num_phases(num_phases),
    .nvm_store(nvm_store), .nvm_restore(nvm_restore), .clear_faults(clear_faults),
    .conv_en(conv_en), .vout_abs_mode(vout_abs_mode), .vout_target(vout_target),
    .vout_sense(vout_sense), .ton_rise_cycles(16'h0004), .oc_fault_in(oc_fault_in),
    .oc_warn_in(oc_warn_in), .eff_oc_fault(eff_oc_fault), .eff_oc_warn(eff_oc_warn),
    .eff_gain_q10(eff_gain_q10), .stack_offset_q8(stack_offset_q8), .ov_pct_q(ov_pct_q),
    .shutdown(shutdown), .latched_off(latched_off), .status_byte_ov(status_byte_ov),
    .status_word_vout(status_word_vout), .status_vout_ov(status_vout_ov),
    .status_cml_data(status_cml_data), .alert_n(alert_n));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic rd_chk(input logic [7:0] code, input logic is_byte, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    host.get(code, is_byte, d, ok);
    chk_bit("rd_valid", 1'b1, ok);
    chk("rd_data", exp, d);
  endtask : rd_chk

  task automatic clr();
    @(posedge clk);
    clear_faults <= 1'b1;
    @(posedge clk);
    clear_faults <= 1'b0;
    #1;
  endtask : clr

  // Sense above threshold for one cycle
  task automatic trip();
    @(posedge clk);
    vout_sense <= 16'h1200;
    @(posedge clk);
    vout_sense <= 16'h0800;
    #1;
  endtask : trip

  task automatic results();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    results();
  end

  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(trim_ov_pkg::CMD_GAIN, 1'b0, trim_ov_pkg::GAIN_RST); // default word
    rd_chk(trim_ov_pkg::CMD_OV_ACTION, 1'b1, 16'h0080); // byte read
    chk("eff_gain", 16'h0400, eff_gain_q10); // unity gain
    chk("ov_pct", 16'h01e0, {6'h00, ov_pct_q}); // idle step
    $display("test reset done");
    host.put(trim_ov_pkg::CMD_GAIN, 16'hc840, 1'b0);
    @(posedge clk);
    #1;
    chk("eff_gain", 16'h0200, eff_gain_q10); // half gain
    chk("eff_oc_fault", 16'h0080, eff_oc_fault); // scaled
    chk("eff_oc_warn", 16'h0100, eff_oc_warn); // scaled
    host.put(trim_ov_pkg::CMD_GAIN, 16'h0003, 1'b0);
    chk_bit("cml", 1'b1, status_cml_data); // gain too large
    chk_bit("alert_n", 1'b0, alert_n); // host told
    rd_chk(trim_ov_pkg::CMD_GAIN, 1'b0, 16'hc840); // old word kept
    clr();
    $display("test gain done");
    phase_sel <= 8'h01;
    // Stack sum lags the per-phase store by one cycle
    host.put(trim_ov_pkg::CMD_OFFSET, 16'he018, 1'b0);
    @(posedge clk);
    #1;
    chk("stack", 16'h0180, stack_offset_q8); // one phase
    rd_chk(trim_ov_pkg::CMD_OFFSET, 1'b0, 16'he018); // own phase
    phase_sel <= 8'h02;
    host.put(trim_ov_pkg::CMD_OFFSET, 16'he780, 1'b0);
    @(posedge clk);
    #1;
    chk("stack", 16'hf980, stack_offset_q8); // sum with minimum
    phase_sel <= 8'h03;
    host.put(trim_ov_pkg::CMD_OFFSET, 16'he080, 1'b0);
    chk_bit("cml", 1'b1, status_cml_data); // above range
    chk("stack", 16'hf980, stack_offset_q8); // unchanged
    clr();
    phase_sel <= trim_ov_pkg::PHASE_ALL;
    host.put(trim_ov_pkg::CMD_OFFSET, 16'he040, 1'b0);
    @(posedge clk);
    #1;
    chk("stack", 16'h0400, stack_offset_q8); // split equally
    rd_chk(trim_ov_pkg::CMD_OFFSET, 1'b0, 16'he040); // phase zero times four
    phase_sel <= 8'h02;
    rd_chk(trim_ov_pkg::CMD_OFFSET, 1'b0, 16'he010); // quotient per phase
    phase_sel <= 8'h00;
    host.put(trim_ov_pkg::CMD_OFFSET, 16'hd041, 1'b0);
    @(posedge clk);
    #1;
    chk("stack", 16'h0404, stack_offset_q8); // fine step live
    host.put(trim_ov_pkg::CMD_GAIN, 16'hc103, 1'b0);
    @(posedge clk);
    nvm_store <= 1'b1;
    @(posedge clk);
    nvm_store <= 1'b0;
    nvm_restore <= 1'b1;
    @(posedge clk);
    nvm_restore <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("eff_gain", 16'h0410, eff_gain_q10); // nearest 1/64
    chk("stack", 16'h0400, stack_offset_q8); // nearest stored
    $display("test offset done");
    host.put(trim_ov_pkg::CMD_OV_LIMIT, 16'h0215, 1'b0);
    chk("ov_pct", 16'h01b8, {6'h00, ov_pct_q}); // rounds to 110
    trip();
    chk_bit("vout_ov", 1'b1, status_vout_ov); // armed while idle
    clr();
    conv_en <= 1'b1;
    host.put(trim_ov_pkg::CMD_OV_ACTION, 16'h0000, 1'b1);
    chk("ov_pct", 16'h01a4, {6'h00, ov_pct_q}); // rounds to 105
    trip();
    chk_bit("status_byte", 1'b1, status_byte_ov); // byte flag
    chk_bit("status_word", 1'b1, status_word_vout); // word flag
    chk_bit("vout_ov", 1'b1, status_vout_ov); // vout flag
    chk_bit("alert_n", 1'b0, alert_n); // host told
    chk_bit("shutdown", 1'b0, shutdown); // ignored
    clr();
    host.put(trim_ov_pkg::CMD_OV_LIMIT, 16'h02d0, 1'b0);
    chk_bit("cml", 1'b1, status_cml_data); // limit above 140
    chk("ov_pct", 16'h01a4, {6'h00, ov_pct_q}); // limit kept
    clr();
    host.put(trim_ov_pkg::CMD_OV_ACTION, 16'h00c0, 1'b1);
    chk_bit("cml", 1'b1, status_cml_data); // field 11b
    clr();
    host.put(trim_ov_pkg::CMD_OV_ACTION, 16'h0080, 1'b0);
    chk_bit("cml", 1'b1, status_cml_data); // word to byte command
    clr();
    host.put(trim_ov_pkg::CMD_OV_ACTION, 16'h00b8, 1'b1);
    trip();
    chk_bit("shutdown", 1'b1, shutdown); // retry forever
    chk_bit("latched", 1'b0, latched_off); // no latch
    repeat (3) @(posedge clk);
    #1;
    chk_bit("shutdown", 1'b1, shutdown); // still waiting
    @(posedge clk);
    #1;
    chk_bit("shutdown", 1'b0, shutdown); // one rise time wait
    clr();
    host.put(trim_ov_pkg::CMD_OV_ACTION, 16'h0080, 1'b1);
    trip();
    chk_bit("shutdown", 1'b1, shutdown); // shut down
    chk_bit("latched", 1'b1, latched_off); // latch off
    repeat (2) @(posedge clk);
    #1;
    chk_bit("latched", 1'b1, latched_off); // stays latched
    // Absolute limit maps to a fixed fraction of the target
    vout_abs_mode <= 1'b1;
    host.put(trim_ov_pkg::CMD_OV_LIMIT, 16'h1200, 1'b0);
    chk("ov_pct", 16'h01c2, {6'h00, ov_pct_q}); // absolute to 112.5
    vout_target <= 16'h2000;
    rd_chk(trim_ov_pkg::CMD_OV_LIMIT, 1'b0, 16'h1200); // word kept
    chk("ov_pct", 16'h01c2, {6'h00, ov_pct_q}); // still relative
    $display("test overvoltage done");
    results();
  end
endmodule : tb
